// ==== src/aac_clock_div.sv ====
`timescale 1ns/1ns
module aac_clock_div
   import aac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [ANALOG_CLOCK_RATIO_W-1:0] analogClockRatio,
   input wire logic [ARBITER_SLOT_DIVIDER_W-1:0] arbiterSlotDivider,
   input wire logic [1:0] roundLengthField,
   output logic analogTick,
   output logic slotTick,
   output logic roundTick
);
   typedef struct packed {
      logic [ANALOG_CLOCK_RATIO_W-1:0] aCnt;
      logic [ARBITER_SLOT_DIVIDER_W-1:0] dCnt;
      logic [4:0] sCnt;
      logic aTick;
      logic sTick;
      logic rTick;
   } aac_div_t;
   aac_div_t s_q, s_d;
   logic [4:0] lastSlot;

   always_comb begin
      unique case (roundLengthField)
         RND_4: lastSlot = SLOTS_4;
         RND_8: lastSlot = SLOTS_8;
         RND_16: lastSlot = SLOTS_16;
         default: lastSlot = SLOTS_20;
      endcase
      s_d = s_q;
      s_d.aTick = 1'b0;
      s_d.sTick = 1'b0;
      s_d.rTick = 1'b0;
      // ratio field n gives n+1, at least 2
      if ((s_q.aCnt >= analogClockRatio && s_q.aCnt >= ANALOG_CLOCK_RATIO_MIN) || s_q.aCnt >= 5'h1f) begin
         s_d.aCnt = '0;
         s_d.aTick = 1'b1;
      end else begin
         s_d.aCnt = s_q.aCnt + 5'h01;
      end
      if (s_q.dCnt >= arbiterSlotDivider) begin
         s_d.dCnt = '0;
         s_d.sTick = 1'b1;
         if (s_q.sCnt >= lastSlot) begin
            s_d.sCnt = '0;
            s_d.rTick = 1'b1;
         end else begin
            s_d.sCnt = s_q.sCnt + 5'h01;
         end
      end else begin
         s_d.dCnt = s_q.dCnt + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign analogTick = s_q.aTick;
   assign slotTick = s_q.sTick;
   assign roundTick = s_q.rTick;
endmodule : aac_clock_div

// ==== src/aac_ctrl.sv ====
`timescale 1ns/1ns
module aac_ctrl
   import aac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic startupTrimTrigger,
   input wire aac_global_t globalConfigRegister,
   input wire logic [1:0] roundLengthField,
   input wire aac_req_t [NUM_SRC-1:0] srcReq,
   input wire logic [1:0][STC_W-1:0] groupInputClass,
   input wire logic [1:0][STC_W-1:0] globalInputClass,
   input wire logic [RES_W-1:0] analogData,
   output logic trimInProgress,
   output logic [NUM_SRC-1:0] srcAck,
   output logic [CH_W-1:0] muxChannel,
   output logic precharge,
   output logic sampling,
   output logic msbDoubleClock,
   output aac_result_t result
);
   typedef struct packed {
      aac_state_t st;
      logic trimArm;
      logic trimBusy;
      logic [7:0] cnt;
      logic [SRC_W-1:0] curSrc;
      logic [1:0] curPrio;
      logic [CH_W-1:0] chan;
      logic [STC_W-1:0] stc;
      logic bwd;
      logic [NUM_SRC-1:0] ack;
      logic prep;
      logic samp;
      logic msbDbl;
      aac_result_t res;
   } aac_ctrl_t;
   aac_ctrl_t s_q, s_d;

   logic analogTick, slotTick;
   logic winValid;
   logic [SRC_W-1:0] winSrc;
   logic [1:0] winPrio;
   logic busy;
   logic [STC_W-1:0] winStc;

   aac_clock_div u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .analogClockRatio(globalConfigRegister.analogClockRatio),
      .arbiterSlotDivider(globalConfigRegister.arbiterSlotDivider),
      .roundLengthField(roundLengthField),
      .analogTick(analogTick),
      .slotTick(slotTick),
      .roundTick()
   );

   // highest priority pending source, lowest index on ties
   always_comb begin
      winValid = 1'b0;
      winSrc = '0;
      winPrio = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (srcReq[i].pending && (!winValid || srcReq[i].sourcePriorityField >= winPrio)) begin
            winValid = 1'b1;
            winSrc = SRC_W'(i);
            winPrio = srcReq[i].sourcePriorityField;
         end
      end
      // class of the winner, never the running one
      if (srcReq[winSrc].useGlobalClass) begin
         winStc = globalInputClass[srcReq[winSrc].classSel];
      end else begin
         winStc = groupInputClass[srcReq[winSrc].classSel];
      end
   end

   assign busy = (s_q.st == AAC_PREP) || (s_q.st == AAC_SAMPLE) || (s_q.st == AAC_CONV);

   always_comb begin
      s_d = s_q;
      s_d.ack = '0;
      s_d.res.valid = 1'b0;
      s_d.msbDbl = MSB_DOUBLE_RESET;
      if (startupTrimTrigger && s_q.st != AAC_TRIM) begin
         s_d.trimArm = 1'b1;
      end
      unique case (s_q.st)
         AAC_IDLE: begin
            if (s_q.trimArm && analogTick) begin
               s_d.trimArm = 1'b0;
               s_d.trimBusy = 1'b1;
               s_d.cnt = TRIM_STEPS;
               s_d.st = AAC_TRIM;
            end else if (!s_q.trimArm && winValid && slotTick && s_q.ack == '0) begin
               // acked source still shows pending for one cycle
               s_d.curSrc = winSrc;
               s_d.curPrio = winPrio;
               s_d.chan = srcReq[winSrc].channel;
               s_d.stc = winStc;
               s_d.bwd = srcReq[winSrc].brokenWireEnable;
               s_d.cnt = srcReq[winSrc].brokenWireEnable ? PREP_CYCLES : winStc;
               s_d.st = srcReq[winSrc].brokenWireEnable ? AAC_PREP : AAC_SAMPLE;
            end
         end
         AAC_TRIM: begin
            if (analogTick) begin
               if (s_q.cnt == '0) begin
                  s_d.trimBusy = 1'b0;
                  s_d.st = AAC_IDLE;
               end else begin
                  s_d.cnt = s_q.cnt - 8'h01;
               end
            end
         end
         AAC_PREP: begin
            if (analogTick) begin
               if (s_q.cnt == '0) begin
                  s_d.cnt = s_q.stc;
                  s_d.st = AAC_SAMPLE;
               end else begin
                  s_d.cnt = s_q.cnt - 8'h01;
               end
            end
         end
         AAC_SAMPLE: begin
            if (analogTick) begin
               if (s_q.cnt == '0) begin
                  s_d.cnt = CONV_CYCLES + MSB_CYCLES;
                  s_d.st = AAC_CONV;
               end else begin
                  s_d.cnt = s_q.cnt - 8'h01;
               end
            end
         end
         AAC_CONV: begin
            if (analogTick) begin
               if (s_q.cnt == '0) begin
                  // only a finished conversion answers its source
                  s_d.res.valid = 1'b1;
                  s_d.res.source = s_q.curSrc;
                  s_d.res.channel = s_q.chan;
                  s_d.res.data = analogData;
                  s_d.ack[s_q.curSrc] = 1'b1;
                  s_d.st = AAC_IDLE;
               end else begin
                  s_d.cnt = s_q.cnt - 8'h01;
               end
            end
         end
         default: s_d.st = AAC_IDLE;
      endcase
      // cancel-inject: victim stays pending, so it reruns later
      if (busy && winValid && slotTick && winSrc != s_q.curSrc
          && winPrio > s_q.curPrio
          && winPrio != PRIO_LOWEST
          && srcReq[winSrc].sourceStartModeBit != CSM_WAIT) begin
         s_d.res.valid = 1'b0;
         s_d.ack = '0;
         s_d.curSrc = winSrc;
         s_d.curPrio = winPrio;
         s_d.chan = srcReq[winSrc].channel;
         s_d.stc = winStc;
         s_d.bwd = srcReq[winSrc].brokenWireEnable;
         s_d.cnt = srcReq[winSrc].brokenWireEnable ? PREP_CYCLES : winStc;
         s_d.st = srcReq[winSrc].brokenWireEnable ? AAC_PREP : AAC_SAMPLE;
      end
      s_d.prep = (s_d.st == AAC_PREP);
      s_d.samp = (s_d.st == AAC_SAMPLE);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= AAC_IDLE;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign trimInProgress = s_q.trimBusy;
   assign srcAck = s_q.ack;
   assign muxChannel = s_q.chan;
   assign precharge = s_q.prep;
   assign sampling = s_q.samp;
   assign msbDoubleClock = s_q.msbDbl;
   assign result = s_q.res;
endmodule : aac_ctrl

// ==== src/aac_pkg.sv ====
package aac_pkg;
   localparam int NUM_SRC = 4;
   localparam int SRC_W = 2;
   localparam int CH_W = 5;
   localparam int RES_W = 12;
   localparam int STC_W = 8;
   localparam int ANALOG_CLOCK_RATIO_W = 5;
   localparam int ARBITER_SLOT_DIVIDER_W = 2;
   localparam logic [1:0] PRIO_LOWEST = 2'h0;
   localparam logic CSM_WAIT = 1'h0;
   localparam logic [4:0] ANALOG_CLOCK_RATIO_MIN = 5'h01;
   localparam logic [1:0] RND_4 = 2'h0;
   localparam logic [1:0] RND_8 = 2'h1;
   localparam logic [1:0] RND_16 = 2'h2;
   localparam logic [4:0] SLOTS_4 = 5'h03;
   localparam logic [4:0] SLOTS_8 = 5'h07;
   localparam logic [4:0] SLOTS_16 = 5'h0f;
   localparam logic [4:0] SLOTS_20 = 5'h13;
   localparam logic [7:0] TRIM_STEPS = 8'h3f;
   localparam logic [7:0] PREP_CYCLES = 8'h02;
   localparam logic [7:0] CONV_CYCLES = 8'h0c;
   localparam logic [7:0] MSB_CYCLES = 8'h01;
   localparam logic MSB_DOUBLE_RESET = 1'h0;

   typedef enum logic [4:0] {
      AAC_IDLE = 5'h01,
      AAC_TRIM = 5'h02,
      AAC_PREP = 5'h04,
      AAC_SAMPLE = 5'h08,
      AAC_CONV = 5'h10
   } aac_state_t;

   typedef struct packed {
      logic [ANALOG_CLOCK_RATIO_W-1:0] analogClockRatio;
      logic [ARBITER_SLOT_DIVIDER_W-1:0] arbiterSlotDivider;
      logic [1:0] roundLengthField;
      logic msbDoubleClock;
   } aac_global_t;

   typedef struct packed {
      logic pending;
      logic [1:0] sourcePriorityField;
      logic sourceStartModeBit;
      logic [CH_W-1:0] channel;
      logic classSel;
      logic useGlobalClass;
      logic brokenWireEnable;
   } aac_req_t;

   typedef struct packed {
      logic valid;
      logic [SRC_W-1:0] source;
      logic [CH_W-1:0] channel;
      logic [RES_W-1:0] data;
   } aac_result_t;
endpackage : aac_pkg

// ==== testbench/aac_analog_src.sv ====
`timescale 1ns/1ns
module aac_analog_src
   import aac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sampling,
   input wire logic [CH_W-1:0] muxChannel,
   output logic [RES_W-1:0] analogData
);
   logic [RES_W-1:0] tog_q = '0;
   logic [CH_W-1:0] chan_q = '0;
   // reads zero while sampling, held level afterwards
   always_ff @(posedge clk_sys) begin
      tog_q <= ~tog_q + 12'h001;
      if (sampling) begin
         chan_q <= muxChannel;
      end
   end
   assign analogData = sampling ? tog_q : {7'h35, chan_q};
endmodule : aac_analog_src

// ==== testbench/aac_ctrl_sva.sv ====
`timescale 1ns/1ns
module aac_ctrl_sva
   import aac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic startupTrimTrigger,
   input wire logic trimInProgress,
   input wire logic [NUM_SRC-1:0] srcAck,
   input wire logic precharge,
   input wire logic sampling,
   input wire logic msbDoubleClock,
   input wire aac_result_t result
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [11:0] trimCnt_q;
   always_ff @(posedge clk_sys) begin
      trimCnt_q <= (!rst_n || !trimInProgress) ? 12'h000 : trimCnt_q + 12'h001;
   end
   sequence trimGo;
      $rose(startupTrimTrigger) && !trimInProgress && clkEn;
   endsequence
   sequence trimHold;
      trimInProgress [*8];
   endsequence
   a_msb_stays_zero: assert property (msbDoubleClock == 1'h0) else $error("msb set");
   a_trim_starts: assert property (trimGo |-> ##[1:40] trimInProgress)
      else $error("trim late");
   a_trim_holds: assert property ($rose(trimInProgress) |-> trimHold) else $error("trim short");
   a_trim_ends: assert property (trimCnt_q < 12'h900) else $error("trim stuck");
   a_trim_no_conv: assert property (trimInProgress |-> !sampling && !result.valid)
      else $error("conversion in trim");
   a_ack_pulse: assert property (|srcAck |=> srcAck == '0) else $error("ack long");
   a_ack_matches: assert property (result.valid |-> srcAck[result.source] && $onehot(srcAck))
      else $error("ack mismatch");
   a_ack_has_result: assert property (|srcAck |-> result.valid) else $error("ack alone");
   a_prep_then_sample: assert property ($fell(precharge) |-> sampling)
      else $error("prep not followed");
endmodule : aac_ctrl_sva

bind aac_ctrl aac_ctrl_sva aac_ctrl_sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
   .startupTrimTrigger(startupTrimTrigger), .trimInProgress(trimInProgress), .srcAck(srcAck),
   .precharge(precharge), .sampling(sampling), .msbDoubleClock(msbDoubleClock),
   .result(result));

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import aac_pkg::*;
   typedef struct packed {
      logic [SRC_W-1:0] src;
      logic [CH_W-1:0] ch;
      logic [9:0] smp;
      logic bw;
   } aac_note_t;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic trig = 1'h0;
   aac_global_t cfg = '{5'h01, 2'h0, 2'h0, 1'h0};
   logic prepSeen = 1'h0;
   logic [1:0] rnd = 2'h0;
   aac_req_t [NUM_SRC-1:0] req = '0;
   logic [1:0][STC_W-1:0] grpCls = '0;
   logic [1:0][STC_W-1:0] glbCls = '0;
   logic trimInProgress, precharge, sampling, msbDoubleClock;
   logic [NUM_SRC-1:0] srcAck;
   logic [CH_W-1:0] muxChannel;
   logic [RES_W-1:0] analogData;
   aac_result_t result;
   aac_note_t notes[$];
   aac_note_t n;
   logic [31:0] seed = 32'hcf10;
   logic [9:0] smpCnt = '0;
   logic [9:0] smpLen = '0;
   int fails = 0;
   int samplesChecked = 0;
   always #25 clk_sys = ~clk_sys;
   aac_ctrl aac_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'h1),
      .startupTrimTrigger(trig), .globalConfigRegister(cfg), .roundLengthField(rnd),
      .srcReq(req), .groupInputClass(grpCls), .globalInputClass(glbCls),
      .analogData(analogData), .trimInProgress(trimInProgress), .srcAck(srcAck),
      .muxChannel(muxChannel), .precharge(precharge), .sampling(sampling),
      .msbDoubleClock(msbDoubleClock), .result(result));
   aac_analog_src aac_analog_src_i (.clk_sys(clk_sys), .sampling(sampling),
      .muxChannel(muxChannel), .analogData(analogData));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input logic ok, input string msg);
      samplesChecked++;
      if (ok !== 1'h1) begin
         fails++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d fails %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   // note order is the expected result order; injected goes first
   task automatic arm(input int s, input logic [1:0] p, input logic m, input logic w,
         input logic f);
      aac_note_t e;
      logic [STC_W-1:0] st;
      seed = xs(seed);
      req[s] <= '{1'h1, p, m, seed[4:0], seed[5], seed[6], w};
      cfg.arbiterSlotDivider <= seed[8:7];
      st = seed[6] ? glbCls[seed[5]] : grpCls[seed[5]];
      e = '{s[SRC_W-1:0], seed[4:0], ({2'h0, st} + 10'h001) * 10'h002, w};
      if (f) begin
         notes.push_front(e);
      end else begin
         notes.push_back(e);
      end
   endtask : arm
   task automatic drain;
      for (int i = 0; i < 3000 && notes.size() != 0; i++) @(posedge clk_sys);
      chk(notes.size() == 0, "result missing");
      @(posedge clk_sys);
   endtask : drain
   always @(posedge clk_sys) begin
      smpCnt <= (sampling === 1'h1) ? smpCnt + 10'h001 : 10'h000;
      if (sampling === 1'h1) begin
         smpLen <= smpCnt + 10'h001;
      end
      if (precharge === 1'h1) begin
         prepSeen <= 1'h1;
      end
      if (result.valid === 1'h1) begin
         req[result.source].pending <= 1'h0;
         prepSeen <= 1'h0;
         if (notes.size() == 0) begin
            chk(1'h0, "stray result");
         end else begin
            n = notes.pop_front();
            chk(result.source === n.src && result.channel === n.ch, "order");
            chk(result.data === {7'h35, n.ch}, "data");
            chk(smpLen + 10'h001 >= n.smp && smpLen <= n.smp + 10'h001, "sample");
            chk(prepSeen === n.bw, "prep");
         end
      end
   end
   initial begin
      #(50 * 40000);
      fails++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      seed = xs(seed);
      rst_n <= 1'h1;
      grpCls <= {4'h0, seed[3:0], 4'h0, seed[7:4]};
      glbCls <= {4'h0, seed[11:8], 4'h0, seed[15:12]};
      @(posedge clk_sys);
      chk(trimInProgress === 1'h0 && srcAck === 4'h0 && msbDoubleClock === 1'h0, "rst");
      trig <= 1'h1;
      @(posedge clk_sys);
      trig <= 1'h0;
      for (int i = 0; i < 40 && trimInProgress !== 1'h1; i++) @(posedge clk_sys);
      chk(trimInProgress === 1'h1, "trim start");
      for (int i = 0; i < 3000 && trimInProgress !== 1'h0; i++) @(posedge clk_sys);
      chk(trimInProgress === 1'h0, "trim end");
      $display("test trim done");
      for (int r = 0; r < 4; r++) begin
         rnd <= r[1:0];
         arm(r, 2'h1, 1'h1, r[0], 1'h0);
         drain();
      end
      $display("test classes done");
      for (int c = 0; c < 3; c++) begin
         arm(0, 2'h1, 1'h1, 1'h0, 1'h0);
         for (int i = 0; i < 900 && sampling !== 1'h1; i++) @(posedge clk_sys);
         for (int i = 0; i < 900 && sampling !== 1'h0; i++) @(posedge clk_sys);
         arm(c + 1, c == 0 ? 2'h2 : c == 1 ? 2'h0 : 2'h3, c != 2, c == 0, c == 0);
         drain();
      end
      $display("test cancel done");
      test_done();
   end
endmodule : tb_top
